// ==== eep_pkg.sv ====
// Purpose: Shared constants and types for the two-wire memory slave front end
// Assumes: Core clock of 125 MHz; link clock far slower and sampled
// Notes:   Timing counts derive from the figures held here
package eep_pkg;
    // Core clock and programming time
    localparam int          CLK_HZ          = 125_000_000;
    localparam int          PROG_TIME_MS    = 10;
    localparam int          PROG_CYCLES_DEF = (CLK_HZ / 1000) * PROG_TIME_MS;
    localparam int          PROG_CNT_W      = 21;
    // Array and byte geometry
    localparam int          ADDR_W          = 10;
    localparam int          BYTE_W          = 8;
    localparam int          MEM_WORDS       = 1024;
    // Pin sampling
    localparam int          PIN_W           = 3;
    localparam int          PIN_SCL         = 0;
    localparam int          PIN_SDA         = 1;
    localparam int          PIN_CS          = 2;
    // Select word layout
    localparam logic [3:0]  FIXED_PATTERN   = 4'hA;
    localparam int          SEL_PAT_HI      = 7;
    localparam int          SEL_PAT_LO      = 4;
    localparam int          SEL_BIT_TWO     = 3;
    localparam int          SEL_BIT_ONE     = 2;
    localparam int          SEL_BIT_ZERO    = 1;
    localparam int          SEL_DIR         = 0;
    localparam logic        DIR_READ        = 1'b1;
    // Bit counter marks
    localparam logic [3:0]  CNT_BYTE_DONE   = 4'h8;
    localparam logic [3:0]  CNT_ACK_DONE    = 4'h9;
    // Reset values
    localparam logic [ADDR_W-1:0]     ADDR_RST = 10'h000;
    localparam logic [BYTE_W-1:0]     BYTE_RST = 8'h00;
    localparam logic [PROG_CNT_W-1:0] CNT_RST  = 21'h000000;

    // Protocol states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_CTRL   = 6'h02,
        ST_ADDR   = 6'h04,
        ST_WDATA  = 6'h08,
        ST_RDATA  = 6'h10,
        ST_IGNORE = 6'h20
    } eep_state_t;
endpackage

// ==== eep_pin_sync.sv ====
// Purpose: Two-stage synchroniser for the bus pins plus one delayed copy
// Assumes: Pins are asynchronous to i_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module eep_pin_sync (
    // Clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rstn,
    // Raw pins
    input  wire logic [eep_pkg::PIN_W-1:0] i_pins,
    // Synchronised level and its previous sample
    output logic      [eep_pkg::PIN_W-1:0] o_level,
    output logic      [eep_pkg::PIN_W-1:0] o_last
);
    import eep_pkg::*;

    typedef struct packed {
        logic [PIN_W-1:0] meta;
        logic [PIN_W-1:0] sync;
        logic [PIN_W-1:0] last;
    } eep_sync_t;

    eep_sync_t r;
    eep_sync_t next_r;

    // Shift chain
    always_comb begin
        next_r      = r;
        next_r.meta = i_pins;
        next_r.sync = r.meta;
        next_r.last = r.sync;
    end

    // Idle bus reads high
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign o_level = r.sync;
    assign o_last  = r.last;
endmodule

// ==== eep_slave.sv ====
// Purpose: Two-wire slave front end of a 1024 x 8 nonvolatile memory
// Assumes: Master drives the link clock; data line is open drain
// Notes:   Programming is modelled by a timer, the word is written at its end
`timescale 1ns/100ps

// What this block does
// - Write select: pattern, select bits, zero, acknowledge
// - Read select: same word, eighth bit one
// - Word address byte received MSB first, acknowledged
// - Write data byte received MSB first, acknowledged
// - Read data shifted out MSB first, master acknowledges
// - Polling: no acknowledge to a read select while programming runs
// - Write select aborts programming; read select ignored
// - Programming starts on stop after 27 clocks
// - Low master acknowledge increments address, wrapping at 1024
module eep_slave #(
    parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // Link pins
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda_out,
    output logic      o_sda_oe,
    // Select input condition
    input  wire logic i_chip_select,
    // Status
    output logic      o_busy
);
    import eep_pkg::*;

    typedef struct packed {
        eep_state_t              st;
        logic [3:0]              bitcnt;
        logic [BYTE_W-1:0]       shreg;
        logic [BYTE_W-1:0]       txreg;
        logic [ADDR_W-1:0]       addr;
        logic [BYTE_W-1:0]       wdata;
        logic                    sda_oe;
        logic                    tx;
        logic                    more;
        logic                    wr_ready;
        logic                    busy;
        logic [PROG_CNT_W-1:0]   prog_cnt;
        logic [ADDR_W-1:0]       prog_addr;
        logic [BYTE_W-1:0]       prog_data;
    } eep_core_t;

    localparam eep_core_t CORE_RST = '{
        st: ST_IDLE, bitcnt: 4'h0, shreg: BYTE_RST, txreg: BYTE_RST,
        addr: ADDR_RST, wdata: BYTE_RST, sda_oe: 1'b0, tx: 1'b0,
        more: 1'b0, wr_ready: 1'b0, busy: 1'b0, prog_cnt: CNT_RST,
        prog_addr: ADDR_RST, prog_data: BYTE_RST
    };
    localparam logic [PROG_CNT_W-1:0] PROG_LOAD = PROG_CYCLES[PROG_CNT_W-1:0];
    localparam logic [PROG_CNT_W-1:0] CNT_ONE   = 21'h000001;

    eep_core_t         r;
    eep_core_t         next_r;
    logic [BYTE_W-1:0] mem [MEM_WORDS];
    logic [PIN_W-1:0]  pin_now;
    logic [PIN_W-1:0]  pin_last;
    logic              scl_rise;
    logic              scl_fall;
    logic              bus_start;
    logic              bus_stop;
    logic              prog_done;
    logic              sel_match;

    // Pin synchroniser
    eep_pin_sync u_sync (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_pins  ({i_chip_select, i_sda, i_scl}),
        .o_level (pin_now),
        .o_last  (pin_last)
    );

    // Link events seen on the core clock
    assign scl_rise  = pin_now[PIN_SCL] & ~pin_last[PIN_SCL];
    assign scl_fall  = ~pin_now[PIN_SCL] & pin_last[PIN_SCL];
    assign bus_start = pin_now[PIN_SCL] & pin_last[PIN_SCL]
                       & pin_last[PIN_SDA] & ~pin_now[PIN_SDA];
    assign bus_stop  = pin_now[PIN_SCL] & pin_last[PIN_SCL]
                       & ~pin_last[PIN_SDA] & pin_now[PIN_SDA];
    assign prog_done = r.busy && (r.prog_cnt == CNT_ONE);

    // Fixed pattern and chip select bit against the select input
    assign sel_match = (r.shreg[SEL_PAT_HI:SEL_PAT_LO] == FIXED_PATTERN)
                       && (r.shreg[SEL_BIT_ZERO] == pin_now[PIN_CS]);

    // Protocol and programming control
    always_comb begin
        next_r = r;
        // Programming timer
        if (prog_done) begin
            next_r.busy = 1'b0;
        end else if (r.busy) begin
            next_r.prog_cnt = r.prog_cnt - CNT_ONE;
        end

        if (bus_start) begin
            next_r.st       = ST_CTRL;
            next_r.bitcnt   = 4'h0;
            next_r.sda_oe   = 1'b0;
            next_r.wr_ready = 1'b0;
            next_r.tx       = 1'b0;
        end else if (bus_stop) begin
            // Only a complete three-word entry starts programming
            if (r.wr_ready) begin
                next_r.busy      = 1'b1;
                next_r.prog_cnt  = PROG_LOAD;
                next_r.prog_addr = r.addr;
                next_r.prog_data = r.wdata;
            end
            next_r.st       = ST_IDLE;
            next_r.sda_oe   = 1'b0;
            next_r.wr_ready = 1'b0;
            next_r.tx       = 1'b0;
        end else if (scl_rise && r.st != ST_IDLE) begin
            if (r.bitcnt < CNT_BYTE_DONE) begin
                // Bits arrive MSB first
                next_r.shreg  = {r.shreg[BYTE_W-2:0], pin_now[PIN_SDA]};
                next_r.bitcnt = r.bitcnt + 4'h1;
            end else if (r.bitcnt == CNT_BYTE_DONE) begin
                next_r.bitcnt = CNT_ACK_DONE;
                if (r.st == ST_RDATA && r.tx) begin
                    // Master acknowledge low asks for the next byte
                    next_r.more = ~pin_now[PIN_SDA];
                    if (!pin_now[PIN_SDA]) begin
                        next_r.addr = r.addr + 10'h001;
                    end
                end
            end
        end else if (scl_fall && r.st != ST_IDLE) begin
            if (r.st == ST_RDATA && r.bitcnt == CNT_BYTE_DONE) begin
                next_r.sda_oe = 1'b0;
            end else if (r.st == ST_RDATA && r.tx && r.bitcnt != CNT_ACK_DONE) begin
                next_r.sda_oe = ~r.txreg[BYTE_W-1];
                next_r.txreg  = {r.txreg[BYTE_W-2:0], 1'b0};
            end else if (r.bitcnt == CNT_BYTE_DONE) begin
                unique case (r.st)
                    ST_CTRL: begin
                        if (!sel_match) begin
                            next_r.st = ST_IGNORE;
                        end else if (r.shreg[SEL_DIR] == DIR_READ) begin
                            if (r.busy) begin
                                next_r.st = ST_IGNORE;
                            end else begin
                                next_r.sda_oe = 1'b1;
                                next_r.st     = ST_RDATA;
                                next_r.more   = 1'b1;
                            end
                        end else begin
                            next_r.busy          = 1'b0;
                            next_r.sda_oe        = 1'b1;
                            next_r.addr[9]       = r.shreg[SEL_BIT_TWO];
                            next_r.addr[8]       = r.shreg[SEL_BIT_ONE];
                            next_r.st            = ST_ADDR;
                        end
                    end
                    ST_ADDR: begin
                        next_r.addr[7:0] = r.shreg;
                        next_r.sda_oe    = 1'b1;
                        next_r.st        = ST_WDATA;
                    end
                    ST_WDATA: begin
                        next_r.wdata    = r.shreg;
                        next_r.sda_oe   = 1'b1;
                        next_r.wr_ready = 1'b1;
                        next_r.st       = ST_IGNORE;
                    end
                    ST_IGNORE: begin
                        next_r.sda_oe = 1'b0;
                    end
                    default: begin
                        next_r.st = ST_IGNORE;
                    end
                endcase
            end else if (r.bitcnt == CNT_ACK_DONE) begin
                // End of the acknowledge slot
                next_r.bitcnt = 4'h0;
                next_r.sda_oe = 1'b0;
                if (r.st == ST_RDATA) begin
                    if (r.more) begin
                        // Load the addressed word and drive its MSB
                        next_r.tx     = 1'b1;
                        next_r.sda_oe = ~mem[r.addr][BYTE_W-1];
                        next_r.txreg  = {mem[r.addr][BYTE_W-2:0], 1'b0};
                    end else begin
                        next_r.tx = 1'b0;
                        next_r.st = ST_IGNORE;
                    end
                end
            end
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r <= CORE_RST;
        end else begin
            r <= next_r;
        end
    end

    // Word written when the programming time runs out
    always_ff @(posedge i_clk) begin
        if (prog_done) begin
            mem[r.prog_addr] <= r.prog_data;
        end
    end

    // Open-drain data line only ever pulls low
    assign o_sda_out = 1'b0;
    assign o_sda_oe  = r.sda_oe;
    assign o_busy    = r.busy;
endmodule

// ==== eep_note_end.sv ====
// Purpose: Reserved file, holds no logic of its own
// Assumes: Slave and synchroniser live in their own files
// Notes:   Kept empty so that only two design modules exist

// ==== eep_slave_assertions.sv ====
// Purpose: Port checker for the two-wire memory slave
// Assumes: Link clock period of eight core clocks
// Notes:   Bound onto every eep_slave instance
`timescale 1ns/100ps
module eep_slave_checker #(
    parameter int PROG_CYCLES = 50
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic i_chip_select,
    input wire logic o_busy
);
    int busy_cnt;
    // Length of the current busy spell
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn)
            busy_cnt <= 0;
        else
            busy_cnt <= o_busy ? busy_cnt + 1 : 0;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    AST_OUT_LOW: assert property (o_sda_out == 1'b0)
        else $error("open drain value not low");
    AST_OE_SYNC_DELAY: assert property ($fell(i_scl) |=> $stable(o_sda_oe)[*2])
        else $error("data line moved too soon after clock fall");
    AST_OE_HIGH_STABLE: assert property (i_scl && $past(i_scl, 3) |-> $stable(o_sda_oe))
        else $error("data line moved while clock high");
    AST_BUSY_MIN: assert property ($rose(o_busy) |-> o_busy[*8])
        else $error("busy spell too short");
    AST_BUSY_ON_STOP: assert property ($rose(o_busy) |-> i_scl && i_sda && !$past(i_sda, 6))
        else $error("busy rose without stop");
    AST_BUSY_BOUND: assert property (busy_cnt <= PROG_CYCLES)
        else $error("busy spell too long");
    AST_IDLE_AFTER_STOP: assert property (i_scl && $rose(i_sda) |-> ##6 !o_sda_oe)
        else $error("data line driven after stop");
    AST_RESET_QUIET: assert property (!$past(i_rstn) |-> !o_sda_oe && !o_busy)
        else $error("outputs active after reset");
    COV_BUSY: cover property ($rose(o_busy));
    COV_DONE: cover property ($fell(o_busy));
    COV_ACK: cover property ($rose(o_sda_oe));
endmodule
bind eep_slave eep_slave_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .i_chip_select(i_chip_select), .o_busy(o_busy));

// ==== eep_master_model.sv ====
// Purpose: Bus controller model driving the link clock and data
// Assumes: Data line pulled up; model only pulls low
// Notes:   Eight core clocks a link period, four low and four high
`timescale 1ns/100ps
module eep_master_model (
    input  wire logic i_clk,
    output logic      o_scl,
    output logic      o_sda_low,
    input  wire logic i_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // One bit: change in low phase, sample late in high phase
    task automatic put_bit(input logic b, output logic r);
        o_scl <= 1'b0;
        tick(2);
        o_sda_low <= ~b;
        tick(2);
        o_scl <= 1'b1;
        tick(3);
        r = i_sda;
        tick(1);
    endtask
    // Clock rests high between frames, runs only inside one
    logic in_frame = 1'b0;
    // Start, also used as repeated start
    task automatic go_start();
        if (in_frame) begin
            o_scl <= 1'b0;
            tick(2);
            o_sda_low <= 1'b0;
            tick(2);
            o_scl <= 1'b1;
        end
        in_frame = 1'b1;
        tick(4);
        o_sda_low <= 1'b1;
        tick(4);
    endtask
    task automatic go_stop();
        in_frame = 1'b0;
        o_scl <= 1'b0;
        tick(2);
        o_sda_low <= 1'b1;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        o_sda_low <= 1'b0;
        tick(8);
    endtask
    // Byte out MSB first, then release for the memory acknowledge
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(d[i], r);
        put_bit(1'b1, ack);
    endtask
    // Byte in MSB first, then drive the master acknowledge
    task automatic get_byte(input logic ack_in, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(ack_in, r);
    endtask
endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the two-wire memory slave
// Assumes: Programming timer of 400 clocks, outlasting a poll and an abort
// Notes:   Chip select input high except in one select scenario
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, e, a); end end
module testbench;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic cs = 1'b1;
    logic scl, m_low, oe, busy;
    wire  sda = ~(oe | m_low);
    int   n_errors = 0;
    int   checked = 0;
    int   cycles = 0;
    eep_slave #(.PROG_CYCLES(400)) uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl),
        .i_sda(sda), .o_sda_out(), .o_sda_oe(oe), .i_chip_select(cs), .o_busy(busy));
    eep_master_model m (.i_clk(i_clk), .o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic sel(input logic [9:0] a, input logic dir, output logic ack);
        m.send_byte({4'hA, a[9:8], 1'b1, dir}, ack);
    endtask
    task automatic head(input logic [9:0] a, input logic [7:0] d);
        logic k;
        m.go_start();
        sel(a, 1'b0, k);
        `CHK("write select", 1'b0, k)
        m.send_byte(a[7:0], k);
        `CHK("address", 1'b0, k)
        m.send_byte(d, k);
        `CHK("data", 1'b0, k)
        m.go_stop();
        `CHK("busy", 1'b1, busy)
    endtask
    task automatic write_pair();
        head(10'h3FF, 8'h5A);
        for (int k = 0; k < 500 && busy; k++) @(posedge i_clk);
        `CHK("done", 1'b0, busy)
        head(10'h000, 8'hC3);
        for (int k = 0; k < 500 && busy; k++) @(posedge i_clk);
        `CHK("done again", 1'b0, busy)
    endtask
    task automatic poll_abort();
        logic k;
        head(10'h000, 8'h96);
        m.go_start();
        sel(10'h000, 1'b1, k);
        `CHK("poll busy", 1'b1, k)
        m.go_stop();
        m.go_start();
        sel(10'h000, 1'b0, k);
        `CHK("abort ack", 1'b0, k)
        m.go_stop();
        `CHK("aborted", 1'b0, busy)
        m.go_start();
        sel(10'h000, 1'b1, k);
        `CHK("poll done", 1'b0, k)
        m.go_stop();
    endtask
    task automatic read_wrap();
        logic k;
        logic [7:0] d;
        m.go_start();
        sel(10'h3FF, 1'b0, k);
        m.send_byte(8'hFF, k);
        m.go_start();
        sel(10'h3FF, 1'b1, k);
        `CHK("read select", 1'b0, k)
        m.get_byte(1'b0, d);
        `CHK("byte 3FF", 8'h5A, d)
        m.get_byte(1'b1, d);
        `CHK("byte 000", 8'hC3, d)
        m.go_stop();
    endtask
    task automatic bad_words();
        logic k;
        m.go_start();
        m.send_byte(8'hB0, k);
        `CHK("bad pattern", 1'b1, k)
        m.go_start();
        m.send_byte(8'hA0, k);
        `CHK("bad select", 1'b1, k)
        m.go_stop();
        cs <= 1'b0;
        m.go_start();
        m.send_byte(8'hA0, k);
        `CHK("low select", 1'b0, k)
        m.go_stop();
        cs <= 1'b1;
        m.go_start();
        sel(10'h001, 1'b0, k);
        m.go_stop();
        `CHK("short write", 1'b0, busy)
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        write_pair();
        poll_abort();
        read_wrap();
        bad_words();
        give_verdict();
    end
endmodule
